// >>> include/oag_pkg.sv
// package of constants and carrier types for the operand address generator
package oag_pkg;

  localparam int unsigned OAG_ADDR_W = 16;
  localparam int unsigned OAG_BYTE_W = 8;

  // fixed windows of the memory map
  localparam logic [15:0] OAG_SADDR_BASE = 16'hFE80;
  localparam logic [15:0] OAG_SADDR_LAST = 16'hFF1F;
  localparam logic [15:0] OAG_RAM_FIRST = 16'hFE80;
  localparam logic [15:0] OAG_RAM_LAST = 16'hFEFF;
  localparam logic [15:0] OAG_SFR_FIRST = 16'hFF00;
  localparam logic [15:0] OAG_SFR_SHORT_LAST = 16'hFF1F;
  localparam logic [7:0] OAG_SFR_HIGH = 8'hFF;
  localparam logic [6:0] OAG_SADDR_HIGH7 = 7'h7F;
  localparam logic [7:0] OAG_SADDR_WRAP_MAX = 8'h1F;
  localparam int unsigned OAG_SADDR_BIT8 = 8;

  // opcode of the accumulator load through the pointer pair
  localparam logic [7:0] OAG_OP_LOAD_PTR = 8'h2B;

  // register numbers: byte registers 0..7, pairs 0..3
  localparam logic [2:0] OAG_R_X = 3'h0;
  localparam logic [2:0] OAG_R_A = 3'h1;
  localparam logic [2:0] OAG_R_C = 3'h2;
  localparam logic [2:0] OAG_R_B = 3'h3;
  localparam logic [2:0] OAG_R_E = 3'h4;
  localparam logic [2:0] OAG_R_D = 3'h5;
  localparam logic [2:0] OAG_R_L = 3'h6;
  localparam logic [2:0] OAG_R_H = 3'h7;
  localparam logic [1:0] OAG_RP_ACC = 2'h0;
  localparam logic [1:0] OAG_RP_BC = 2'h1;
  localparam logic [1:0] OAG_RP_PTR = 2'h2;
  localparam logic [1:0] OAG_RP_BASE = 2'h3;

  // addressing modes issued by the decoder
  typedef enum logic [3:0] {
    OAG_MODE_NONE = 4'h0,
    OAG_MODE_DIRECT = 4'h1,
    OAG_MODE_SHORT = 4'h2,
    OAG_MODE_SFR = 4'h3,
    OAG_MODE_REG = 4'h4,
    OAG_MODE_INDIRECT = 4'h5,
    OAG_MODE_BASED = 4'h6,
    OAG_MODE_STACK = 4'h7,
    OAG_MODE_JUMP = 4'h8
  } oag_mode_type;

  // stack operation kinds
  typedef enum logic [2:0] {
    OAG_STK_PUSH = 3'h0,
    OAG_STK_POP = 3'h1,
    OAG_STK_CALL = 3'h2,
    OAG_STK_RET = 3'h3,
    OAG_STK_ISAVE = 3'h4,
    OAG_STK_IREST = 3'h5
  } oag_stack_type;

  // one request from the instruction decoder
  typedef struct packed {
    oag_mode_type mode;
    logic [15:0] imm16;
    logic [7:0] imm8;
    logic [2:0] regCode;
    logic [1:0] pairCode;
    logic pairWord;
    oag_stack_type stackOp;
    logic [7:0] opcode;
  } oag_req_type;

  // one answer toward the memory and register side
  typedef struct packed {
    logic memValid;
    logic [15:0] memAddr;
    logic regValid;
    logic regWord;
    logic [2:0] regSel;
    logic [1:0] pairSel;
    logic pcLoad;
    logic [15:0] pcValue;
    logic inRam;
    logic inShortSfr;
    logic fault;
  } oag_resp_type;

  // register file contents, 16 bits per pair
  typedef struct packed {
    logic [15:0] accPair;
    logic [15:0] bcPair;
    logic [15:0] ptrPair;
    logic [15:0] basePair;
    logic [15:0] stackPtr;
  } oag_regs_type;

endpackage

// >>> logic/oag_reg_file.sv
// register file: eight byte registers, four pairs, stack pointer
`timescale 1ns/10ps
module oag_reg_file
  import oag_pkg::*;
#(
  parameter int unsigned REG_COUNT = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic byteWrEn,
  input wire logic [2:0] byteWrSel,
  input wire logic [7:0] byteWrData,
  input wire logic pairWrEn,
  input wire logic [1:0] pairWrSel,
  input wire logic [15:0] pairWrData,
  input wire logic spWrEn,
  input wire logic [15:0] spWrData,
  input wire logic [2:0] byteRdSel,
  output logic [7:0] byteRdData,
  output oag_regs_type regs
);

  logic [7:0] bankReg [REG_COUNT];
  logic [15:0] spReg;

  // byte writes and pair writes share the array; pair n is registers 2n+1:2n
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_byte
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          bankReg[gi] <= 8'h00;
        end else if (pairWrEn && pairWrSel == 2'(gi / 2)) begin
          bankReg[gi] <= (gi % 2 == 1) ? pairWrData[15:8] : pairWrData[7:0];
        end else if (byteWrEn && byteWrSel == 3'(gi)) begin
          bankReg[gi] <= byteWrData;
        end
      end
    end
  endgenerate

  // stack pointer, written by the core on push and pop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      spReg <= OAG_RAM_LAST;
    end else if (spWrEn) begin
      spReg <= spWrData;
    end
  end

  // functional names of the pairs  (see [R10])
  assign regs.accPair = {bankReg[OAG_R_A], bankReg[OAG_R_X]};
  assign regs.bcPair = {bankReg[OAG_R_B], bankReg[OAG_R_C]};
  assign regs.ptrPair = {bankReg[OAG_R_D], bankReg[OAG_R_E]};
  assign regs.basePair = {bankReg[OAG_R_H], bankReg[OAG_R_L]};
  assign regs.stackPtr = spReg;
  assign byteRdData = bankReg[byteRdSel];

endmodule

// >>> logic/oag_top.sv
// operand and branch address generator for the 8-bit core
// Functional notes
// [R1] the register-pair jump loads the whole accumulator pair into the program counter.
// [R2] direct mode uses the 16-bit immediate as the operand address unchanged.
// [R3] short direct mode reaches only the 160 bytes FE80H to FF1FH through an 8-bit field.
// [R4] short direct sets address bit 8 for field 00H to 1FH, clears it otherwise, field is low byte.
// [R5] short direct drives address bits 15 to 9 all to one.
// [R6] word short direct operands are given only at even addresses by the decoder.
// [R7] special-register mode places the 8-bit field as low byte under FFH, range FF00H to FFFFH.
// [R8] special registers at FF00H to FF1FH are reached by short direct, not special-register mode.
// [R9] register mode picks one of eight byte registers with a 3-bit code.
// [R10] the register file holds registers 0 to 7 and pairs 0 to 3, also by functional name.
// [R11] register indirect uses the pointer pair or base pair chosen by the pair code.
// [R12] opcode 00101011 is the accumulator load through the pointer pair.
// [R13] based mode adds the zero-extended offset to the base pair and drops the carry.
// [R14] stack mode uses the stack pointer for push, pop, call, return and interrupt save.
// [R15] the stack pointer is kept inside internal high-speed RAM by software.
// [R16] internal RAM is FE80H to FEFFH and short-reach special registers are FF00H to FF1FH.
`timescale 1ns/10ps
module oag_top
  import oag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reqValid,
  input oag_req_type req,
  input wire logic byteWrEn,
  input wire logic [2:0] byteWrSel,
  input wire logic [7:0] byteWrData,
  input wire logic pairWrEn,
  input wire logic [1:0] pairWrSel,
  input wire logic [15:0] pairWrData,
  input wire logic spWrEn,
  input wire logic [15:0] spWrData,
  output oag_resp_type resp,
  output logic [7:0] regOperand,
  output logic [15:0] programCounter,
  output logic loadPtrSeen
);

  oag_regs_type regs;
  logic [7:0] byteRdData;
  oag_resp_type resp_reg;
  oag_resp_type resp_next;
  logic [7:0] regOperand_reg;
  logic [15:0] pc_reg;
  logic loadPtr_reg;
  logic loadPtr_next;
  logic [15:0] stackAddr;

  oag_reg_file #(
    .REG_COUNT(8)
  ) u_regs (
    .clk_sys(clk_sys),
    .rst(rst),
    .byteWrEn(byteWrEn),
    .byteWrSel(byteWrSel),
    .byteWrData(byteWrData),
    .pairWrEn(pairWrEn),
    .pairWrSel(pairWrSel),
    .pairWrData(pairWrData),
    .spWrEn(spWrEn),
    .spWrData(spWrData),
    .byteRdSel(req.regCode),
    .byteRdData(byteRdData),
    .regs(regs)
  );

  // short direct mapping: high bits forced to one, bit 8 from the field range
  function automatic logic [15:0] shortAddr(input logic [7:0] field);
    logic bit8;
    bit8 = (field <= OAG_SADDR_WRAP_MAX); // see [R4]
    return {OAG_SADDR_HIGH7, bit8, field}; // see [R5] see [R3]
  endfunction

  // region tags used for every generated address
  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // pair by number; only pointer and base pairs are legal indirect pointers
  function automatic logic [15:0] pairValue(input logic [1:0] sel, input oag_regs_type r);
    logic [15:0] v;
    case (sel)
      OAG_RP_ACC: v = r.accPair;
      OAG_RP_BC: v = r.bcPair;
      OAG_RP_PTR: v = r.ptrPair;
      default: v = r.basePair;
    endcase
    return v;
  endfunction

  // push and call pre-decrement is done by the core; here the pointer is used as is
  assign stackAddr = regs.stackPtr; // see [R14]

  // address generation per mode
  always_comb begin
    resp_next = '0;
    loadPtr_next = 1'b0;
    if (reqValid) begin
      case (req.mode)
        OAG_MODE_DIRECT: begin
          resp_next.memValid = 1'b1;
          resp_next.memAddr = req.imm16; // see [R2]
        end
        OAG_MODE_SHORT: begin
          resp_next.memValid = 1'b1;
          resp_next.memAddr = shortAddr(req.imm8); // see [R3]
          // odd word address is a decoder error, flagged rather than fixed
          resp_next.fault = req.pairWord & req.imm8[0]; // see [R6]
          // field 20H..7FH lies outside the window
          resp_next.fault = resp_next.fault |
            !inRange(resp_next.memAddr, OAG_SADDR_BASE, OAG_SADDR_LAST);
        end
        OAG_MODE_SFR: begin
          resp_next.memValid = 1'b1;
          resp_next.memAddr = {OAG_SFR_HIGH, req.imm8}; // see [R7]
          // low 32 special registers belong to short direct mode
          resp_next.fault = inRange(resp_next.memAddr, OAG_SFR_FIRST,
                                    OAG_SFR_SHORT_LAST); // see [R8]
        end
        OAG_MODE_REG: begin
          resp_next.regValid = 1'b1;
          resp_next.regWord = req.pairWord;
          resp_next.regSel = req.regCode; // see [R9]
          resp_next.pairSel = req.pairCode; // see [R10]
        end
        OAG_MODE_INDIRECT: begin
          resp_next.memValid = 1'b1;
          resp_next.memAddr = pairValue(req.pairCode, regs); // see [R11]
          resp_next.fault = (req.pairCode != OAG_RP_PTR) && (req.pairCode != OAG_RP_BASE);
          loadPtr_next = (req.opcode == OAG_OP_LOAD_PTR); // see [R12]
          if (loadPtr_next) begin
            resp_next.memAddr = regs.ptrPair; // see [R12]
            resp_next.fault = 1'b0;
          end
        end
        OAG_MODE_BASED: begin
          resp_next.memValid = 1'b1;
          // sum kept to 16 bits so the carry is lost and the address wraps
          resp_next.memAddr = 16'(regs.basePair + {8'h00, req.imm8}); // see [R13]
        end
        OAG_MODE_STACK: begin
          resp_next.memValid = 1'b1;
          resp_next.memAddr = stackAddr; // see [R14]
          // stack outside RAM is unsupported; flagged for the core
          resp_next.fault = !inRange(stackAddr, OAG_RAM_FIRST, OAG_RAM_LAST); // see [R15]
        end
        OAG_MODE_JUMP: begin
          resp_next.pcLoad = 1'b1;
          resp_next.pcValue = regs.accPair; // see [R1]
        end
        default: begin
          resp_next = '0;
        end
      endcase
      resp_next.inRam = resp_next.memValid &
        inRange(resp_next.memAddr, OAG_RAM_FIRST, OAG_RAM_LAST); // see [R16]
      resp_next.inShortSfr = resp_next.memValid &
        inRange(resp_next.memAddr, OAG_SFR_FIRST, OAG_SFR_SHORT_LAST); // see [R16]
    end
  end

  // answer register, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp_reg <= '0;
      loadPtr_reg <= 1'b0;
    end else begin
      resp_reg <= resp_next;
      loadPtr_reg <= loadPtr_next;
    end
  end

  // selected byte register, captured for register mode only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regOperand_reg <= 8'h00;
    end else if (reqValid && req.mode == OAG_MODE_REG) begin
      regOperand_reg <= byteRdData; // see [R9]
    end
  end

  // program counter image, loaded by the pair jump
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc_reg <= 16'h0000;
    end else if (resp_next.pcLoad) begin
      pc_reg <= regs.accPair; // see [R1]
    end
  end

  assign resp = resp_reg;
  assign regOperand = regOperand_reg;
  assign programCounter = pc_reg;
  assign loadPtrSeen = loadPtr_reg;

endmodule

// >>> sim/oag_dec_model.sv
// model of the instruction decoder issuing address requests
`timescale 1ns/10ps
module oag_dec_model
  import oag_pkg::*;
(
  input wire logic clk_sys,
  output logic reqValid,
  output oag_req_type req
);
  initial begin
    reqValid = 1'b0;
    req = '0;
  end
  // one request per call, held over the taking edge, then released
  task automatic send(input oag_req_type r);
    @(posedge clk_sys);
    #1;
    if (r.mode == OAG_MODE_SHORT && r.pairWord) begin
      r.imm8[0] = 1'b0;
    end
    reqValid = 1'b1;
    req = r;
    @(posedge clk_sys);
    #1;
    reqValid = 1'b0;
    req = ~r; // released fields show junk so stale values are never trusted
  endtask
endmodule

// >>> sim/oag_top_properties.sv
// port-level checker of the operand address generator
`timescale 1ns/10ps
module oag_top_properties
  import oag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reqValid,
  input oag_req_type req,
  input oag_resp_type resp,
  input wire logic [15:0] programCounter,
  input wire logic loadPtrSeen
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // mode of the request taken at this edge
  oag_mode_type m;
  assign m = reqValid ? req.mode : OAG_MODE_NONE;
  property p_direct;
    m == OAG_MODE_DIRECT |=> resp.memValid && resp.memAddr == $past(req.imm16);
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
  property p_short_set;
    m == OAG_MODE_SHORT && req.imm8 <= 8'h1F |=> resp.memAddr == {7'h7F, 1'b1, $past(req.imm8)};
  endproperty
  a_short_set: assert property (p_short_set) else $error("short bit 8 not set");
  property p_short_clr;
    m == OAG_MODE_SHORT && req.imm8[7] |=>
      resp.memAddr == {7'h7F, 1'b0, $past(req.imm8)} && resp.inRam;
  endproperty
  a_short_clr: assert property (p_short_clr) else $error("short bit 8 not clear");
  property p_sfr;
    m == OAG_MODE_SFR |=> resp.memAddr == {8'hFF, $past(req.imm8)};
  endproperty
  a_sfr: assert property (p_sfr) else $error("register space address wrong");
  property p_sfr_low;
    m == OAG_MODE_SFR && req.imm8 <= 8'h1F |=> resp.fault;
  endproperty
  a_sfr_low: assert property (p_sfr_low) else $error("low register not flagged");
  property p_jump;
    m == OAG_MODE_JUMP |=> resp.pcLoad && programCounter == resp.pcValue;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded");
  property p_load;
    m == OAG_MODE_INDIRECT && req.opcode == OAG_OP_LOAD_PTR |=> loadPtrSeen;
  endproperty
  a_load: assert property (p_load) else $error("pointer load not seen");
  property p_reg;
    m == OAG_MODE_REG |=> resp.regValid && resp.regSel == $past(req.regCode);
  endproperty
  a_reg: assert property (p_reg) else $error("register select wrong");
  property p_stack;
    m == OAG_MODE_STACK |=> resp.memValid ##1 !resp.memValid || $past(reqValid);
  endproperty
  a_stack: assert property (p_stack) else $error("stack access missing");
  c_short: cover property (m == OAG_MODE_SHORT ##1 resp.inRam);
  c_jump: cover property (m == OAG_MODE_JUMP ##1 resp.pcLoad);
  c_load: cover property (loadPtrSeen);
endmodule

bind oag_top oag_top_properties i_props (
  .clk_sys(clk_sys),
  .rst(rst),
  .reqValid(reqValid),
  .req(req),
  .resp(resp),
  .programCounter(programCounter),
  .loadPtrSeen(loadPtrSeen)
);

// >>> sim/testbench.sv
// self-checking bench of the operand address generator
`timescale 1ns/10ps
module testbench
  import oag_pkg::*;
;
  logic clk_sys;
  logic rst;
  logic reqValid;
  logic byteWrEn;
  logic pairWrEn;
  logic spWrEn;
  logic loadPtrSeen;
  logic [2:0] byteWrSel;
  logic [1:0] pairWrSel;
  logic [7:0] byteWrData;
  logic [7:0] regOperand;
  logic [15:0] pairWrData;
  logic [15:0] spWrData;
  logic [15:0] programCounter;
  oag_req_type req;
  oag_resp_type resp;
  int err_total = 0;
  int check_count = 0;
  oag_top i_oag_top (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid), .req(req),
    .byteWrEn(byteWrEn), .byteWrSel(byteWrSel), .byteWrData(byteWrData),
    .pairWrEn(pairWrEn), .pairWrSel(pairWrSel), .pairWrData(pairWrData),
    .spWrEn(spWrEn), .spWrData(spWrData), .resp(resp), .regOperand(regOperand),
    .programCounter(programCounter), .loadPtrSeen(loadPtrSeen));
  oag_dec_model i_oag_dec_model (.clk_sys(clk_sys), .reqValid(reqValid), .req(req));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // register write: k 0 byte, 1 pair, 2 stack pointer
  task automatic wr(input int k, input logic [2:0] s, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    byteWrEn = (k == 0);
    pairWrEn = (k == 1);
    spWrEn = (k == 2);
    byteWrSel = s;
    pairWrSel = s[1:0];
    byteWrData = d[7:0];
    pairWrData = d;
    spWrData = d;
    @(posedge clk_sys);
    #1;
    {byteWrEn, pairWrEn, spWrEn} = 3'h0;
  endtask
  task automatic go(input oag_mode_type m, input logic [15:0] a, input logic [7:0] b,
      input logic [2:0] c, input logic [7:0] op);
    oag_req_type r;
    r = '0;
    r.mode = m;
    r.imm16 = a;
    r.imm8 = b;
    r.regCode = c;
    r.pairCode = c[1:0];
    r.stackOp = oag_stack_type'(c);
    r.opcode = op;
    i_oag_dec_model.send(r);
  endtask
  task automatic t_short();
    logic [7:0] f [4] = '{8'h00, 8'h1F, 8'h80, 8'hFF};
    foreach (f[i]) begin
      go(OAG_MODE_SHORT, 16'h0, f[i], 3'h0, 8'h0);
      chk("short addr", resp.memAddr, {7'h7F, f[i] <= 8'h1F, f[i]});
      chk("short fault", 16'(resp.fault), 16'h0);
      chk("short ram", 16'(resp.inRam), 16'(f[i][7]));
      chk("short sfr", 16'(resp.inShortSfr), 16'(f[i] <= 8'h1F));
    end
    // fields 20H..7FH fall below the window and must be flagged
    go(OAG_MODE_SHORT, 16'h0, 8'h40, 3'h0, 8'h0);
    chk("short outside", 16'(resp.fault), 16'h1);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      wr(0, 3'(i), 16'(i * 17 + 3));
    end
    for (int i = 0; i < 8; i++) begin
      go(OAG_MODE_REG, 16'h0, 8'h0, 3'(i), 8'h0);
      chk("reg operand", 16'(regOperand), 16'(i * 17 + 3));
    end
    wr(1, 3'(OAG_RP_BC), 16'hBBCC);
    go(OAG_MODE_REG, 16'h0, 8'h0, OAG_R_B, 8'h0);
    chk("pair high", 16'(regOperand), 16'h00BB);
  endtask
  task automatic t_mem();
    wr(1, 3'(OAG_RP_ACC), 16'h1234);
    go(OAG_MODE_JUMP, 16'h0, 8'h0, 3'h0, 8'h0);
    chk("pc value", resp.pcValue, 16'h1234);
    chk("pc", programCounter, 16'h1234);
    go(OAG_MODE_DIRECT, 16'hFE80, 8'h0, 3'h0, 8'h0);
    chk("direct", resp.memAddr, 16'hFE80);
    go(OAG_MODE_SFR, 16'h0, 8'h20, 3'h0, 8'h0);
    chk("sfr addr", resp.memAddr, 16'hFF20);
    go(OAG_MODE_SFR, 16'h0, 8'h05, 3'h0, 8'h0);
    chk("sfr low", 16'(resp.fault), 16'h1);
    wr(1, 3'(OAG_RP_PTR), 16'h1111);
    wr(1, 3'(OAG_RP_BASE), 16'hFEA0);
    go(OAG_MODE_INDIRECT, 16'h0, 8'h0, 3'(OAG_RP_BASE), 8'h0);
    chk("ind base", resp.memAddr, 16'hFEA0);
    go(OAG_MODE_INDIRECT, 16'h0, 8'h0, 3'h0, OAG_OP_LOAD_PTR);
    chk("ind ptr", resp.memAddr, 16'h1111);
    chk("ptr load", 16'(loadPtrSeen), 16'h1);
    wr(1, 3'(OAG_RP_BASE), 16'hFFF8);
    go(OAG_MODE_BASED, 16'h0, 8'h10, 3'h0, 8'h0);
    chk("based wrap", resp.memAddr, 16'h0008);
  endtask
  task automatic t_stack();
    wr(2, 3'h0, 16'hFE90); // pointer kept in fast RAM
    for (int k = 0; k < 6; k++) begin
      go(OAG_MODE_STACK, 16'h0, 8'h0, 3'(k), 8'h0);
      chk("stack addr", resp.memAddr, 16'hFE90);
      chk("stack ram", 16'(resp.inRam), 16'h1);
    end
  endtask
  // mid-run reset: pc image cleared, stack pointer back at the top of RAM
  task automatic t_reset();
    @(posedge clk_sys);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("reset pc again", programCounter, 16'h0000);
    go(OAG_MODE_STACK, 16'h0, 8'h0, 3'h0, 8'h0);
    chk("reset stack", resp.memAddr, OAG_RAM_LAST);
    chk("reset stack fault", 16'(resp.fault), 16'h0);
  endtask
  // guard against a hung run
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    {byteWrEn, pairWrEn, spWrEn} = 3'h0;
    {byteWrSel, pairWrSel, byteWrData, pairWrData, spWrData} = '0;
    repeat (16) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("reset pc", programCounter, 16'h0);
    t_mem();
    t_short();
    t_regs();
    t_stack();
    t_reset();
    finish_test();
  end
endmodule
